// [hdl/sua_top.sv]
// Operation
// R1: three modes: asynchronous full duplex, synchronous master, synchronous slave.
// R2: pins serve the port only with port enable and both direction bits set.
// R3: in synchronous mode clock source picks master (internal) or slave (external).
// R4: transmit width bit picks nine-bit or eight-bit transmission.
// R5: transmit enable runs transmitter; synchronous receive enables override it.
// R6: mode bit picks synchronous when set, asynchronous when clear.
// R7: shift register empty flag reads one when idle, resets to one.
// R8: transmit ninth bit is sent as ninth data bit.
// R9: port enable turns the whole serial port on or off.
// R10: receive width bit picks nine-bit or eight-bit reception.
// R11: single receive starts one master reception, cleared by hardware afterwards.
// R12: continuous receive enables reception while set and overrides single receive.
// R13: address detect in asynchronous nine-bit mode accepts only ninth-bit-set frames.
// R14: framing error flag follows the character loaded into the buffer.
// R15: overrun flag clears only when continuous receive is cleared.
// R16: receive ninth bit holds the ninth received bit.
// R17: baud generator is a free-running 8-bit timer set by divisor.
// R18: high speed select affects only asynchronous rate.
// R19: rates are clock over 64(X+1), 16(X+1) or 4(X+1).
// R20: writing the divisor restarts the baud timer at once.
// R21: receive pin sampled three times, majority vote decides the level.
// R22: asynchronous frame: low start, data lsb first, high stop bit.
// R23: completing a character into a full buffer flags overrun, halts reception.
module sua_top import sua_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic txCkIn,
   output logic txCkOut,
   output logic txCkOeN,
   input wire logic rxDtIn,
   output logic rxDtOut,
   output logic rxDtOeN
);
   // ***************************************
   // registers and decode
   // ***************************************
   logic [7:0] txCtrlQ, rxCtrlQ, txDataQ, rxBufQ, divisorQ;
   logic [1:0] portDirQ, preQ, pinSync;
   logic txBufFullQ, rxBufFullQ, ferrQ, oerrQ, rx9dQ;
   logic baudTick, sampleTick, ckPrevQ, ckGenQ, halfQ;
   logic [8:0] txShiftQ, rxShiftQ;
   logic [3:0] txTickQ, txBitQ, rxTickQ, rxBitQ, txLast, rxLast;
   logic txNineQ, vote0Q, vote1Q, vote;
   sua_tx_state_t txStateQ;
   sua_rx_state_t rxStateQ;
   logic syncMode, master, serialOn, txRun, txLoad, shiftEmpty;
   logic rxRunAsync, rxRunSync, rxDone, rxAccept, stopBitQ;
   logic ckRise, ckFall, syncBusy, rxPin, ckPin;
   logic [7:0] rxData;
   logic rxNinth;

   assign syncMode = txCtrlQ[TX_SYNC_BIT]; // R6
   assign master = syncMode && txCtrlQ[TX_CLK_SRC_BIT]; // R3
   assign serialOn = rxCtrlQ[RX_PORT_EN_BIT] && (portDirQ == PORT_DIR_SERIAL); // R2 R9
   assign shiftEmpty = (txStateQ == TX_IDLE); // R7
   assign rxPin = pinSync[0];
   assign ckPin = pinSync[1];

   sua_sync #(.WIDTH(2)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .asyncIn({txCkIn, rxDtIn}),
      .syncOut(pinSync)
   );

   sua_baud_gen u_baud (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(serialOn),
      .divisorWr(regWr && (regAddr == ADDR_BAUD_DIV)),
      .divisorIn(regWrData),
      .divisorQ(divisorQ),
      .tick(baudTick)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         txCtrlQ <= TX_CTRL_RESET;
         portDirQ <= PORT_DIR_RESET;
         txDataQ <= 8'h00;
      end else if (regWr) begin
         if (regAddr == ADDR_TX_CTRL) txCtrlQ <= regWrData;
         if (regAddr == ADDR_PORT_CTRL) portDirQ <= regWrData[1:0];
         if (regAddr == ADDR_TX_DATA) txDataQ <= regWrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rxCtrlQ <= RX_CTRL_RESET;
      end else begin
         if (rxDone && !rxCtrlQ[RX_CONT_BIT]) rxCtrlQ[RX_SINGLE_BIT] <= 1'b0; // R11
         if (regWr && regAddr == ADDR_RX_CTRL) rxCtrlQ <= {regWrData[7:3], 3'h0};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (!regRd) begin
         regRdData <= 8'h00;
      end else begin
         unique case (regAddr)
            ADDR_TX_CTRL: regRdData <= {txCtrlQ[7:4], 1'b0, txCtrlQ[2], shiftEmpty, txCtrlQ[0]}; // R7
            ADDR_RX_CTRL: regRdData <= {rxCtrlQ[7:3], ferrQ, oerrQ, rx9dQ};
            ADDR_BAUD_DIV: regRdData <= divisorQ;
            ADDR_TX_DATA: regRdData <= txDataQ;
            ADDR_RX_BUF: regRdData <= rxBufQ;
            ADDR_PORT_CTRL: regRdData <= {2'h0, txBufFullQ, rxBufFullQ, 2'h0, portDirQ};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // ***************************************
   // bit timing
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !serialOn) begin
         preQ <= 2'h0;
      end else if (baudTick) begin
         preQ <= preQ + 2'h1;
      end
   end

   // sixteen sample ticks per asynchronous bit
   assign sampleTick = txCtrlQ[TX_HIGH_SPEED_BIT] ? baudTick : (baudTick && preQ == LOW_SPEED_LAST); // R18 R19

   assign syncBusy = syncMode && (txStateQ == TX_DATA || rxStateQ == RX_DATA || rxStateQ == RX_STOP);

   // master clock: one toggle every two ticks, period 4(X+1)
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !master || !syncBusy) begin
         halfQ <= 1'b0;
         ckGenQ <= 1'b0;
      end else if (baudTick) begin
         halfQ <= !halfQ;
         if (halfQ) ckGenQ <= !ckGenQ; // R19
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) ckPrevQ <= 1'b1;
      else ckPrevQ <= ckPin;
   end

   always_comb begin
      if (master) begin
         ckRise = syncBusy && baudTick && halfQ && !ckGenQ;
         ckFall = syncBusy && baudTick && halfQ && ckGenQ;
      end else begin
         ckRise = ckPin && !ckPrevQ; // R3
         ckFall = !ckPin && ckPrevQ;
      end
   end

   // ***************************************
   // transmitter
   // ***************************************
   assign txRun = serialOn && txCtrlQ[TX_EN_BIT]
      && !(syncMode && (rxCtrlQ[RX_SINGLE_BIT] || rxCtrlQ[RX_CONT_BIT])); // R5
   assign txLoad = txRun && txBufFullQ && shiftEmpty;
   assign txLast = txNineQ ? LAST_BIT_NINE : LAST_BIT_EIGHT;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         txBufFullQ <= 1'b0;
      end else if (regWr && regAddr == ADDR_TX_DATA) begin
         txBufFullQ <= 1'b1;
      end else if (txLoad) begin
         txBufFullQ <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !serialOn) begin
         txStateQ <= TX_IDLE;
         txShiftQ <= 9'h1ff;
         txTickQ <= 4'h0;
         txBitQ <= 4'h0;
         txNineQ <= 1'b0;
      end else begin
         unique case (txStateQ)
            TX_IDLE: begin
               if (txLoad) begin
                  txShiftQ <= {txCtrlQ[0], txDataQ}; // R8
                  txNineQ <= txCtrlQ[TX_NINE_BIT]; // R4
                  txTickQ <= 4'h0;
                  txBitQ <= 4'h0;
                  txStateQ <= syncMode ? TX_DATA : TX_START; // R1
               end
            end
            TX_START: begin
               if (sampleTick) begin
                  txTickQ <= txTickQ + 4'h1;
                  if (txTickQ == OVERSAMPLE_LAST) txStateQ <= TX_DATA; // R22
               end
            end
            TX_DATA: begin
               if (syncMode ? ckFall : (sampleTick && txTickQ == OVERSAMPLE_LAST)) begin
                  txShiftQ <= {1'b1, txShiftQ[8:1]};
                  txBitQ <= txBitQ + 4'h1;
                  if (txBitQ == txLast) txStateQ <= syncMode ? TX_IDLE : TX_STOP;
               end
               if (sampleTick) txTickQ <= txTickQ + 4'h1;
            end
            TX_STOP: begin
               if (sampleTick) begin
                  txTickQ <= txTickQ + 4'h1;
                  if (txTickQ == OVERSAMPLE_LAST) txStateQ <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // ***************************************
   // receiver
   // ***************************************
   assign rxRunAsync = serialOn && !syncMode && rxCtrlQ[RX_CONT_BIT] && !oerrQ; // R12 R23
   assign rxRunSync = serialOn && master && !oerrQ
      && (rxCtrlQ[RX_CONT_BIT] || rxCtrlQ[RX_SINGLE_BIT]); // R11 R12
   assign vote = (vote0Q && vote1Q) || (vote0Q && rxPin) || (vote1Q && rxPin); // R21
   assign rxLast = rxCtrlQ[RX_NINE_BIT] ? LAST_BIT_NINE : LAST_BIT_EIGHT; // R10

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         vote0Q <= 1'b1;
         vote1Q <= 1'b1;
      end else if (sampleTick) begin
         if (rxTickQ == VOTE_FIRST) vote0Q <= rxPin; // R21
         if (rxTickQ == VOTE_SECOND) vote1Q <= rxPin;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !serialOn) begin
         rxStateQ <= RX_IDLE;
         rxShiftQ <= 9'h000;
         rxTickQ <= 4'h0;
         rxBitQ <= 4'h0;
         stopBitQ <= 1'b1;
      end else begin
         unique case (rxStateQ)
            RX_IDLE: begin
               rxTickQ <= 4'h0;
               rxBitQ <= 4'h0;
               if (rxRunAsync && !rxPin) rxStateQ <= RX_START;
               // slave waits for its first clock edge while enabled
               if (syncMode && (rxRunSync || (!master && rxCtrlQ[RX_CONT_BIT] && !oerrQ)))
                  rxStateQ <= RX_DATA;
            end
            RX_START: begin
               if (sampleTick) begin
                  rxTickQ <= rxTickQ + 4'h1;
                  if (rxTickQ == VOTE_LAST && vote) rxStateQ <= RX_IDLE;
                  if (rxTickQ == OVERSAMPLE_LAST) rxStateQ <= RX_DATA;
               end
            end
            RX_DATA: begin
               if (syncMode ? ckRise : (sampleTick && rxTickQ == VOTE_LAST)) begin
                  rxShiftQ <= {syncMode ? rxPin : vote, rxShiftQ[8:1]}; // R22
                  rxBitQ <= rxBitQ + 4'h1;
                  if (rxBitQ == rxLast) rxStateQ <= RX_STOP;
               end
               if (sampleTick) rxTickQ <= rxTickQ + 4'h1;
            end
            RX_STOP: begin
               if (syncMode ? ckFall : (sampleTick && rxTickQ == VOTE_LAST)) begin
                  stopBitQ <= syncMode ? 1'b1 : vote;
                  rxStateQ <= RX_IDLE;
               end
               if (sampleTick) rxTickQ <= rxTickQ + 4'h1;
            end
         endcase
      end
   end

   assign rxDone = (rxStateQ == RX_STOP) && (syncMode ? ckFall : (sampleTick && rxTickQ == VOTE_LAST));
   assign rxData = rxCtrlQ[RX_NINE_BIT] ? rxShiftQ[7:0] : rxShiftQ[8:1];
   assign rxNinth = rxCtrlQ[RX_NINE_BIT] && rxShiftQ[8];
   assign rxAccept = rxDone && !(!syncMode && rxCtrlQ[RX_NINE_BIT]
      && rxCtrlQ[RX_ADDR_DET_BIT] && !rxShiftQ[8]); // R13

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rxBufQ <= 8'h00;
         rxBufFullQ <= 1'b0;
         ferrQ <= 1'b0;
         rx9dQ <= 1'b0;
      end else if (rxAccept && !rxBufFullQ) begin
         rxBufQ <= rxData;
         rxBufFullQ <= 1'b1;
         ferrQ <= syncMode ? 1'b0 : !vote; // R14 R22
         rx9dQ <= rxNinth; // R16
      end else if (regRd && regAddr == ADDR_RX_BUF) begin
         rxBufFullQ <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) oerrQ <= 1'b0;
      else if (rxAccept && rxBufFullQ) oerrQ <= 1'b1; // R23
      else if (!rxCtrlQ[RX_CONT_BIT]) oerrQ <= 1'b0; // R15
   end

   // ***************************************
   // pins
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !serialOn) begin
         txCkOut <= 1'b1;
         txCkOeN <= 1'b1;
         rxDtOut <= 1'b1;
         rxDtOeN <= 1'b1;
      end else if (!syncMode) begin
         txCkOut <= (txStateQ == TX_START) ? 1'b0 : (txStateQ == TX_DATA) ? txShiftQ[0] : 1'b1; // R22
         txCkOeN <= 1'b0;
         rxDtOut <= 1'b1;
         rxDtOeN <= 1'b1;
      end else begin
         txCkOut <= ckGenQ;
         txCkOeN <= !master;
         rxDtOut <= txShiftQ[0];
         rxDtOeN <= (txStateQ != TX_DATA);
      end
   end

   // ***************************************
   // checks
   // ***************************************
   property p_load;
      @(posedge sys_clk) disable iff (!rst_n)
      regWr && regAddr == ADDR_TX_DATA && !txBufFullQ && shiftEmpty && txRun && $stable(txRun)
      |=> txLoad ##1 !shiftEmpty;
   endproperty
   a_load: assert property (p_load) // R7
      else $error("written character not moved into shift register");

   property p_port_off;
      @(posedge sys_clk) disable iff (!rst_n)
      !serialOn |=> txCkOeN && rxDtOeN && shiftEmpty && (rxStateQ == RX_IDLE);
   endproperty
   a_port_off: assert property (p_port_off) // R2
      else $error("pins driven while port disabled");

   property p_sync_rx_blocks_tx;
      @(posedge sys_clk) disable iff (!rst_n)
      syncMode && (rxCtrlQ[RX_CONT_BIT] || rxCtrlQ[RX_SINGLE_BIT]) |-> !txLoad;
   endproperty
   a_sync_rx_blocks_tx: assert property (p_sync_rx_blocks_tx) // R5
      else $error("transmit started during synchronous receive");

   property p_overrun_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(oerrQ) |-> !$past(rxCtrlQ[RX_CONT_BIT]);
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) // R15
      else $error("overrun cleared while continuous receive set");

   property p_overrun_set;
      @(posedge sys_clk) disable iff (!rst_n)
      rxAccept && rxBufFullQ && !(regRd && regAddr == ADDR_RX_BUF)
      |=> oerrQ && rxBufFullQ && (rxStateQ == RX_IDLE) ##1 (rxStateQ == RX_IDLE);
   endproperty
   a_overrun_set: assert property (p_overrun_set) // R23
      else $error("overrun not flagged or reception not halted");

   property p_single;
      @(posedge sys_clk) disable iff (!rst_n)
      rxDone && master && !rxCtrlQ[RX_CONT_BIT] && !(regWr && regAddr == ADDR_RX_CTRL)
      |=> !rxCtrlQ[RX_SINGLE_BIT];
   endproperty
   a_single: assert property (p_single) // R11
      else $error("single receive not cleared after reception");

   property p_addr_detect;
      @(posedge sys_clk) disable iff (!rst_n)
      rxDone && !syncMode && rxCtrlQ[RX_NINE_BIT] && rxCtrlQ[RX_ADDR_DET_BIT] && !rxShiftQ[8] && !rxBufFullQ
      |=> !rxBufFullQ;
   endproperty
   a_addr_detect: assert property (p_addr_detect) // R13
      else $error("data frame loaded with address detect set");

   property p_stop_high;
      @(posedge sys_clk) disable iff (!rst_n)
      serialOn && !syncMode && (txStateQ == TX_STOP) && $stable(serialOn) && $stable(syncMode)
      |=> txCkOut && !txCkOeN;
   endproperty
   a_stop_high: assert property (p_stop_high) // R22
      else $error("stop bit not driven high");
endmodule

// [hdl/sua_pkg.sv]
package sua_pkg;
   // ***************************************
   // register offsets
   // ***************************************
   localparam logic [7:0] ADDR_RX_CTRL = 8'h18;
   localparam logic [7:0] ADDR_TX_DATA = 8'h19;
   localparam logic [7:0] ADDR_RX_BUF = 8'h1a;
   localparam logic [7:0] ADDR_TX_CTRL = 8'h98;
   localparam logic [7:0] ADDR_BAUD_DIV = 8'h99;
   localparam logic [7:0] ADDR_PORT_CTRL = 8'h9a;
   // ***************************************
   // field positions
   // ***************************************
   localparam int TX_CLK_SRC_BIT = 7;
   localparam int TX_NINE_BIT = 6;
   localparam int TX_EN_BIT = 5;
   localparam int TX_SYNC_BIT = 4;
   localparam int TX_HIGH_SPEED_BIT = 2;
   localparam int RX_PORT_EN_BIT = 7;
   localparam int RX_NINE_BIT = 6;
   localparam int RX_SINGLE_BIT = 5;
   localparam int RX_CONT_BIT = 4;
   localparam int RX_ADDR_DET_BIT = 3;
   // ***************************************
   // reset values and serial direction setting
   // ***************************************
   localparam logic [7:0] TX_CTRL_RESET = 8'h00;
   localparam logic [7:0] RX_CTRL_RESET = 8'h00;
   localparam logic [7:0] BAUD_DIV_RESET = 8'h00;
   localparam logic [1:0] PORT_DIR_RESET = 2'h3;
   localparam logic [1:0] PORT_DIR_SERIAL = 2'h3;
   // ***************************************
   // cycle counts
   // ***************************************
   localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_SECOND = 4'h8;
   localparam logic [3:0] VOTE_LAST = 4'h9;
   localparam logic [3:0] LAST_BIT_NINE = 4'h8;
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
   // ***************************************
   // state machines
   // ***************************************
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA = 4'b0100,
      TX_STOP = 4'b1000
   } sua_tx_state_t;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } sua_rx_state_t;
endpackage

// [hdl/sua_sync.sv]
module sua_sync #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   // ***************************************
   // two-stage synchroniser
   // ***************************************
   logic [WIDTH-1:0] metaQ;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         metaQ <= '1;
         syncOut <= '1;
      end else begin
         metaQ <= asyncIn;
         syncOut <= metaQ;
      end
   end
endmodule

// [hdl/sua_baud_gen.sv]
module sua_baud_gen import sua_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic divisorWr,
   input wire logic [7:0] divisorIn,
   output logic [7:0] divisorQ,
   output logic tick
);
   // ***************************************
   // free-running divisor timer
   // ***************************************
   logic [7:0] cntQ;
   logic [7:0] sinceQ;

   assign tick = enable && (cntQ == divisorQ); // R17

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         divisorQ <= BAUD_DIV_RESET;
      end else if (divisorWr) begin
         divisorQ <= divisorIn;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cntQ <= 8'h00;
      end else if (divisorWr || !enable || tick) begin
         cntQ <= 8'h00; // R20
      end else begin
         cntQ <= cntQ + 8'h01;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n || divisorWr || tick || !enable) begin
         sinceQ <= 8'h00;
      end else begin
         sinceQ <= sinceQ + 8'h01;
      end
   end

   property p_new_rate;
      @(posedge sys_clk) disable iff (!rst_n)
      divisorWr && enable |=> (cntQ == 8'h00) && (divisorQ == $past(divisorIn));
   endproperty
   a_new_rate: assert property (p_new_rate) // R20
      else $error("divisor write did not restart timer");

   property p_period;
      @(posedge sys_clk) disable iff (!rst_n)
      tick |-> (sinceQ == divisorQ);
   endproperty
   a_period: assert property (p_period) // R17
      else $error("baud tick period differs from divisor plus one");
endmodule

// [testbench/sua_partner.sv]
// ***************************************
// serial terminal on the far side
// ***************************************
module sua_partner (
   input wire logic sys_clk,
   input wire logic lineIn,
   output logic lineOut
);
   timeunit 1ns;
   timeprecision 1ns;
   int bitClks = 32;
   initial lineOut = 1'b1;
   // ***************************************
   // frame out: low start, data lsb first, stop level given
   // ***************************************
   task automatic send(input logic [8:0] data, input int nBits, input logic stopLvl);
      for (int i = 0; i <= nBits + 1; i++) begin
         @(posedge sys_clk);
         lineOut <= (i == 0) ? 1'b0 : ((i > nBits) ? stopLvl : data[i-1]);
         repeat (bitClks - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      lineOut <= 1'b1;
   endtask
   // ***************************************
   // frame in: data bit 0 must be one, it gives the bit length
   // ***************************************
   task automatic recv(input int nBits, output logic [8:0] data, output int bitLen, output logic stopLvl);
      int n;
      data = 9'h000;
      stopLvl = 1'b0;
      n = 0;
      while (lineIn !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      while (lineIn === 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      bitLen = 0;
      while (lineIn === 1'b1 && bitLen < 2000) begin
         @(posedge sys_clk);
         bitLen++;
      end
      data[0] = 1'b1;
      for (int i = 1; i <= nBits; i++) begin
         repeat ((i == 1) ? bitLen / 2 : bitLen) @(posedge sys_clk);
         if (i < nBits) begin
            data[i] = lineIn;
         end else begin
            stopLvl = lineIn;
         end
      end
   endtask
endmodule

// [testbench/testbench.sv]
module testbench import sua_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rst_n, regWr, regRd, txCkOut, txCkOeN, rxDtIn, rxDtOut, rxDtOeN, peerLine, stopB;
   logic [7:0] regAddr, regWrData, regRdData, rdv;
   logic [8:0] word;
   int errCount = 0;
   int compares = 0;
   int len, n;
   assign rxDtIn = rxDtOeN ? peerLine : rxDtOut;
   sua_top i_sua_top (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txCkIn(1'b1), .txCkOut(txCkOut),
      .txCkOeN(txCkOeN), .rxDtIn(rxDtIn), .rxDtOut(rxDtOut), .rxDtOeN(rxDtOeN));
   sua_partner i_sua_partner (.sys_clk(sys_clk), .lineIn(txCkOeN ? 1'b1 : txCkOut), .lineOut(peerLine));
   // ***************************************
   // clock, watchdog, report
   // ***************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", errCount, compares);
      if (errCount == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk);
      errCount++;
      conclude();
   end
   // ***************************************
   // register access and compares
   // ***************************************
   task automatic chk(input logic [8:0] exp, input logic [8:0] act);
      compares++;
      if (act !== exp) begin
         errCount++;
         $display("FAIL at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(posedge sys_clk);
      rdv = regRdData;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk({1'b0, exp}, {1'b0, rdv});
   endtask
   task automatic waitLvl(input logic lvl);
      int k;
      k = 0;
      while (txCkOut !== lvl && k < 2000) begin
         @(posedge sys_clk);
         k++;
         n++;
      end
   endtask
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdChk(ADDR_TX_CTRL, 8'h02);
      rdChk(ADDR_RX_CTRL, 8'h00);
      rdChk(ADDR_BAUD_DIV, 8'h00);
      rdChk(ADDR_PORT_CTRL, 8'h03);
      wr(8'h55, 8'hff);
      rdChk(8'h55, 8'h00);
      wr(ADDR_TX_CTRL, 8'hff);
      rdChk(ADDR_TX_CTRL, 8'hf7);
      wr(ADDR_RX_CTRL, 8'h07);
      rdChk(ADDR_RX_CTRL, 8'h00);
      // ***************************************
      // asynchronous transmit, high then low speed
      // ***************************************
      wr(ADDR_BAUD_DIV, 8'h01);
      wr(ADDR_TX_CTRL, 8'h65);
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_TX_DATA, 8'h35);
      @(posedge sys_clk);
      rdChk(ADDR_TX_CTRL, 8'h65);
      i_sua_partner.recv(9, word, len, stopB);
      chk(9'h135, word);
      chk(9'h020, 9'(len));
      chk({8'h00, stopB}, 9'h001);
      wr(ADDR_BAUD_DIV, 8'h00);
      wr(ADDR_TX_CTRL, 8'h20);
      wr(ADDR_TX_DATA, 8'ha5);
      i_sua_partner.recv(8, word, len, stopB);
      chk(9'h0a5, word);
      chk(9'h040, 9'(len));
      // ***************************************
      // asynchronous receive: framing, overrun, address detect
      // ***************************************
      wr(ADDR_BAUD_DIV, 8'h01);
      wr(ADDR_TX_CTRL, 8'h04);
      wr(ADDR_RX_CTRL, 8'h90);
      i_sua_partner.send(9'h05a, 8, 1'b1);
      rdChk(ADDR_RX_BUF, 8'h5a);
      i_sua_partner.send(9'h03c, 8, 1'b0);
      rdChk(ADDR_RX_CTRL, 8'h94);
      rdChk(ADDR_RX_BUF, 8'h3c);
      i_sua_partner.send(9'h011, 8, 1'b1);
      i_sua_partner.send(9'h022, 8, 1'b1);
      rdChk(ADDR_RX_CTRL, 8'h92);
      rdChk(ADDR_RX_BUF, 8'h11);
      wr(ADDR_RX_CTRL, 8'h80);
      rdChk(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_RX_CTRL, 8'hd8);
      i_sua_partner.send(9'h0f0, 9, 1'b1);
      rdChk(ADDR_PORT_CTRL, 8'h03);
      i_sua_partner.send(9'h1f0, 9, 1'b1);
      rdChk(ADDR_RX_CTRL, 8'hd9);
      rdChk(ADDR_RX_BUF, 8'hf0);
      // ***************************************
      // pin release, synchronous master single receive
      // ***************************************
      wr(ADDR_PORT_CTRL, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk({8'h00, txCkOeN}, 9'h001);
      wr(ADDR_PORT_CTRL, 8'h03);
      wr(ADDR_TX_CTRL, 8'h94);
      wr(ADDR_RX_CTRL, 8'ha0);
      repeat (2) @(posedge sys_clk);
      chk({8'h00, txCkOeN}, 9'h000);
      chk({8'h00, rxDtOeN}, 9'h001);
      waitLvl(1'b1);
      n = 0;
      waitLvl(1'b0);
      waitLvl(1'b1);
      chk(9'(n), 9'h008);
      rdv = 8'hff;
      for (int k = 0; k < 100 && rdv[5] !== 1'b0; k++) begin
         rd(ADDR_RX_CTRL);
      end
      rdChk(ADDR_RX_CTRL, 8'h80);
      rdChk(ADDR_RX_BUF, 8'hff);
      conclude();
   end
endmodule
